// [logic/uphyc_defines.vh]
// Behaviour
// - lower bit n written only when bit n+16 of same write is set
// - termination select bit 5 resets 0 (high speed), 1 full speed
// - transceiver select bits 4:3 reset 0: hs, fs, ls, ls-on-fs
// - opmode bits 2:1 reset 0: normal, non-driving, no stuff/nrzi, no sync/eop
// - suspend_n bit 0 resets 0 (suspended); write 1 for normal
// - high-byte stuffing enable bit 15 resets 1, used in opmode 11
// - low-byte stuffing enable bit 14 resets 1, used in opmode 11
// - quiescent test bit 13 resets 0; 1 powers down analog
// - per-port reset bit 12 resets 0; 1 holds tx/rx machines reset
// - reference source bits 11:10 reset 2; code 11 reserved
// - transmitter digital bypass select bit 9 resets 0
// - minus-line bypass driver enable bit 8 resets 0
// - bus valid threshold trim bits 7:5 reset 3
// - otg section disable bit 4 resets 0 (powered)
// - disconnect threshold trim bits 3:1 reset 1
// - common block power control bit 0 resets 1
// - rise/fall trim 15:14 resets 0; crossover 13:12 resets 1, 00 reserved
// - dc level trim 11:8 resets 6; source impedance 7:4 resets F
// - pre-emphasis enable bit 3 resets 1; squelch 2:0 resets 3
// - bits 15,14,13 reset 0: probe comparator, discharge, charge
// - bit 10 sleep_n, bit 8 retention_n, bit 9 reserved reads 0
// - ref frequency 7:5 resets 0, 110 reserved; preemp current 4:3
// - bit 2 enables software control of the phy
`ifndef UPHYC_DEFINES_VH
`define UPHYC_DEFINES_VH

`define UPHYC_OFS_UTMI 12'h118
`define UPHYC_OFS_CTLA 12'h11C
`define UPHYC_OFS_TUNEB 12'h120
`define UPHYC_OFS_PWRC 12'h124

// implemented (writable) bits of each low halfword
`define UPHYC_IMPL_UTMI 16'h003F
`define UPHYC_IMPL_CTLA 16'hFFFF
`define UPHYC_IMPL_TUNEB 16'hFFFF
`define UPHYC_IMPL_PWRC 16'hFDFC

`define UPHYC_RST_UTMI 16'h0000
`define UPHYC_RST_CTLA 16'hC863
`define UPHYC_RST_TUNEB 16'h16FB
`define UPHYC_RST_PWRC 16'h0000

`define UPHYC_REFSEL_LSB 10
`define UPHYC_REFSEL_RSVD 2'h3
`define UPHYC_XOVER_LSB 12
`define UPHYC_XOVER_RSVD 2'h0
`define UPHYC_FSEL_LSB 5
`define UPHYC_FSEL_RSVD 3'h6

`endif

// [logic/uphyc_regs.v]
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uphyc_defines.vh"

module uphyc_regs #(
   parameter AW = 12
) (
   input wire clk,
   input wire arst_n,
   input wire [AW-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // utmi override
   output wire term_sel,
   output wire [1:0] xcvr_sel,
   output wire [1:0] op_mode,
   output wire suspend_n,
   // control word a
   output wire tx_stuff_hi_en,
   output wire tx_stuff_lo_en,
   output wire iddq_pd,
   output wire port_rst,
   output wire [1:0] ref_src_sel,
   output wire bypass_sel,
   output wire bypass_dm_en,
   output wire [2:0] vbus_vld_tune,
   output wire otg_pd,
   output wire [2:0] discon_tune,
   output wire common_on_n,
   // control word b
   output wire [1:0] rise_tune,
   output wire [1:0] xover_tune,
   output wire [3:0] dc_lvl_tune,
   output wire [3:0] fsls_imp_tune,
   output wire preemp_en,
   output wire [2:0] squelch_tune,
   // control word c
   output wire adp_probe_en,
   output wire adp_dischrg_en,
   output wire adp_chrg_en,
   output wire [1:0] src_imp_tune,
   output wire sleep_n,
   output wire retention_n,
   output wire [2:0] ref_freq_sel,
   output wire [1:0] preemp_amp,
   output wire soft_ctl_en,
   // opmode 11 qualified stuffing enables, for the byte datapath
   output wire stuff_hi_act,
   output wire stuff_lo_act
);

   reg [15:0] utmi_r;
   reg [15:0] ctla_r;
   reg [15:0] tuneb_r;
   reg [15:0] pwrc_r;
   reg [15:0] utmi_nxt;
   reg [15:0] ctla_nxt;
   reg [15:0] tuneb_nxt;
   reg [15:0] pwrc_nxt;
   reg [31:0] rdata_nxt;

   // enable halfword gates each low bit; it is never stored
   function [15:0] mwr;
      input [15:0] old;
      input [31:0] wd;
      input [15:0] impl;
      reg [15:0] en;
      begin
         en = wd[31:16] & impl;
         mwr = (old & ~en) | (wd[15:0] & en);
      end
   endfunction

   always @* begin
      utmi_nxt = utmi_r;
      ctla_nxt = ctla_r;
      tuneb_nxt = tuneb_r;
      pwrc_nxt = pwrc_r;
      if (wr) begin
         case (addr)
            `UPHYC_OFS_UTMI: begin
               utmi_nxt = mwr(utmi_r, wdata, `UPHYC_IMPL_UTMI);
            end
            `UPHYC_OFS_CTLA: begin
               ctla_nxt = mwr(ctla_r, wdata, `UPHYC_IMPL_CTLA);
               // a reserved source code would leave the pll unclocked
               if (ctla_nxt[`UPHYC_REFSEL_LSB+1:`UPHYC_REFSEL_LSB] ==
                   `UPHYC_REFSEL_RSVD) begin
                  ctla_nxt[`UPHYC_REFSEL_LSB+1:`UPHYC_REFSEL_LSB] =
                     ctla_r[`UPHYC_REFSEL_LSB+1:`UPHYC_REFSEL_LSB];
               end
            end
            `UPHYC_OFS_TUNEB: begin
               tuneb_nxt = mwr(tuneb_r, wdata, `UPHYC_IMPL_TUNEB);
               if (tuneb_nxt[`UPHYC_XOVER_LSB+1:`UPHYC_XOVER_LSB] ==
                   `UPHYC_XOVER_RSVD) begin
                  tuneb_nxt[`UPHYC_XOVER_LSB+1:`UPHYC_XOVER_LSB] =
                     tuneb_r[`UPHYC_XOVER_LSB+1:`UPHYC_XOVER_LSB];
               end
            end
            `UPHYC_OFS_PWRC: begin
               pwrc_nxt = mwr(pwrc_r, wdata, `UPHYC_IMPL_PWRC);
               if (pwrc_nxt[`UPHYC_FSEL_LSB+2:`UPHYC_FSEL_LSB] ==
                   `UPHYC_FSEL_RSVD) begin
                  pwrc_nxt[`UPHYC_FSEL_LSB+2:`UPHYC_FSEL_LSB] =
                     pwrc_r[`UPHYC_FSEL_LSB+2:`UPHYC_FSEL_LSB];
               end
            end
            default: begin
               utmi_nxt = utmi_r;
            end
         endcase
      end
   end

   always @* begin
      rdata_nxt = 32'h00000000;
      if (rd) begin
         case (addr)
            `UPHYC_OFS_UTMI: rdata_nxt = {16'h0000, utmi_r};
            `UPHYC_OFS_CTLA: rdata_nxt = {16'h0000, ctla_r};
            `UPHYC_OFS_TUNEB: rdata_nxt = {16'h0000, tuneb_r};
            `UPHYC_OFS_PWRC: rdata_nxt = {16'h0000, pwrc_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         utmi_r <= `UPHYC_RST_UTMI;
         ctla_r <= `UPHYC_RST_CTLA;
         tuneb_r <= `UPHYC_RST_TUNEB;
         pwrc_r <= `UPHYC_RST_PWRC;
         rdata <= 32'h00000000;
      end else begin
         utmi_r <= utmi_nxt;
         ctla_r <= ctla_nxt;
         tuneb_r <= tuneb_nxt;
         pwrc_r <= pwrc_nxt;
         rdata <= rdata_nxt;
      end
   end

   assign term_sel = utmi_r[5];
   assign xcvr_sel = utmi_r[4:3];
   assign op_mode = utmi_r[2:1];
   assign suspend_n = utmi_r[0];

   assign tx_stuff_hi_en = ctla_r[15];
   assign tx_stuff_lo_en = ctla_r[14];
   assign iddq_pd = ctla_r[13];
   assign port_rst = ctla_r[12];
   assign ref_src_sel = ctla_r[11:10];
   assign bypass_sel = ctla_r[9];
   assign bypass_dm_en = ctla_r[8];
   assign vbus_vld_tune = ctla_r[7:5];
   assign otg_pd = ctla_r[4];
   assign discon_tune = ctla_r[3:1];
   assign common_on_n = ctla_r[0];

   assign rise_tune = tuneb_r[15:14];
   assign xover_tune = tuneb_r[13:12];
   assign dc_lvl_tune = tuneb_r[11:8];
   assign fsls_imp_tune = tuneb_r[7:4];
   assign preemp_en = tuneb_r[3];
   assign squelch_tune = tuneb_r[2:0];

   assign adp_probe_en = pwrc_r[15];
   assign adp_dischrg_en = pwrc_r[14];
   assign adp_chrg_en = pwrc_r[13];
   assign src_imp_tune = pwrc_r[12:11];
   assign sleep_n = pwrc_r[10];
   assign retention_n = pwrc_r[8];
   assign ref_freq_sel = pwrc_r[7:5];
   assign preemp_amp = pwrc_r[4:3];
   assign soft_ctl_en = pwrc_r[2];

   // outside opmode 11 the phy stuffs on its own; enables only matter there
   assign stuff_hi_act = (utmi_r[2:1] != 2'h3) | ctla_r[15];
   assign stuff_lo_act = (utmi_r[2:1] != 2'h3) | ctla_r[14];

endmodule // uphyc_regs
`default_nettype wire

// [tb/uphyc_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module uphyc_chk #(
   parameter AW = 12
) (
   input wire clk,
   input wire arst_n,
   input wire [AW-1:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire port_rst,
   input wire iddq_pd,
   input wire [1:0] ref_src_sel,
   input wire [1:0] op_mode,
   input wire tx_stuff_hi_en,
   input wire stuff_hi_act
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence wr_a_s;
      wr && addr == 12'h11C;
   endsequence
   idle_rdata_a: assert property (
      !rd |=> rdata == 32'h0) else $error("rdata without read");
   unmapped_rd_a: assert property (
      rd && addr == 12'h200 |=> rdata == 32'h0) else $error("unmapped read");
   utmi_rsvd_a: assert property (
      rd && addr == 12'h118 |=> rdata[31:6] == 26'h0) else $error("utmi rsvd");
   pwrc_rsvd_a: assert property (
      rd && addr == 12'h124 |=> {rdata[31:16], rdata[9], rdata[1:0]} == 19'h0)
      else $error("pwrc rsvd");
   en_clear_a: assert property (
      wr_a_s ##0 !wdata[29] |=> $stable(iddq_pd)) else $error("bit not kept");
   en_set_a: assert property (
      wr_a_s ##0 wdata[28] |=> port_rst == $past(wdata[12]))
      else $error("bit not written");
   refsel_rsvd_a: assert property (
      wr_a_s ##0 wdata[27:26] == 2'h3 && wdata[11:10] == 2'h3
      |=> $stable(ref_src_sel)) else $error("reserved ref source taken");
   stuff_hi_a: assert property (
      stuff_hi_act == (op_mode != 2'h3 || tx_stuff_hi_en))
      else $error("stuff decode");
endmodule // uphyc_chk
bind uphyc_regs uphyc_chk #(.AW(AW)) chk_i (.clk, .arst_n, .addr, .wdata,
   .wr, .rd, .rdata, .port_rst, .iddq_pd, .ref_src_sel, .op_mode,
   .tx_stuff_hi_en, .stuff_hi_act);
`default_nettype wire

// [tb/uphyc_phy_model.sv]
`timescale 1ns/100ps
`default_nettype none
module uphyc_phy_model (
   input wire logic [1:0] op_mode,
   input wire logic tx_stuff_hi_en,
   input wire logic suspend_n,
   output wire logic hi_stuff,
   output wire logic analog_on
);
   // enable only consulted in opmode 11
   assign hi_stuff = (op_mode == 2'h3) ? tx_stuff_hi_en : 1'b1;
   assign analog_on = suspend_n;
endmodule // uphyc_phy_model
`default_nettype wire

// [tb/test_usb_phy_ctrl_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module test_usb_phy_ctrl_regs;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] addr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   wire [31:0] rdata;
   wire [1:0] op_mode;
   wire hi_en, susp_n, hi_act, lo_act, hi_st, an_on;
   int error_cnt = 0;
   int total_checks = 0;
   logic [11:0] ra [14] = '{12'h118, 12'h11C, 12'h120, 12'h124, 12'h118,
      12'h118, 12'h11C, 12'h11C, 12'h11C, 12'h120, 12'h120, 12'h124,
      12'h124, 12'h200};
   logic [31:0] rw [14] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF,
      32'h00010000, 32'h0C000C00, 32'h2000FFFF, 32'h10001000, 32'h30000000,
      32'hFFFF0000, 32'hFFFFFFFF, 32'h00E000C0, 32'hFFFFFFFF};
   logic [31:0] rx [14] = '{32'h0, 32'hC863, 32'h16FB, 32'h0, 32'h3F,
      32'h3E, 32'hC863, 32'hE863, 32'hF863, 32'h16FB, 32'h1000, 32'hFDFC,
      32'hFDFC, 32'h0};
   uphyc_regs #(.AW(12)) uut (
      .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .term_sel(), .xcvr_sel(), .op_mode(op_mode),
      .suspend_n(susp_n), .tx_stuff_hi_en(hi_en), .tx_stuff_lo_en(),
      .iddq_pd(), .port_rst(), .ref_src_sel(), .bypass_sel(),
      .bypass_dm_en(), .vbus_vld_tune(), .otg_pd(), .discon_tune(),
      .common_on_n(), .rise_tune(), .xover_tune(), .dc_lvl_tune(),
      .fsls_imp_tune(), .preemp_en(), .squelch_tune(), .adp_probe_en(),
      .adp_dischrg_en(), .adp_chrg_en(), .src_imp_tune(), .sleep_n(),
      .retention_n(), .ref_freq_sel(), .preemp_amp(), .soft_ctl_en(),
      .stuff_hi_act(hi_act), .stuff_lo_act(lo_act));
   uphyc_phy_model phy (.op_mode(op_mode), .tx_stuff_hi_en(hi_en),
      .suspend_n(susp_n), .hi_stuff(hi_st), .analog_on(an_on));
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata", e, rdata);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always #10 clk = ~clk;
   // no handshake to wait on, so one overall cycle budget cuts any hang
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         bus_wr(ra[i], rw[i]);
         bus_rd(ra[i], rx[i]);
      end
      $display("register rows done");
      bus_wr(12'h11C, 32'h80000000);
      bus_wr(12'h118, 32'h00070007);
      @(negedge clk);
      chk("stuff_hi_act", {31'h0, hi_st}, {31'h0, hi_act});
      chk("stuff_lo_act", 32'h1, {31'h0, lo_act});
      chk("suspend_n", 32'h1, {31'h0, an_on});
      $display("stuffing case done");
      @(posedge clk);
      arst_n <= 1'b0;
      @(negedge clk);
      chk("op_mode", 32'h0, {30'h0, op_mode});
      chk("suspend_n", 32'h0, {31'h0, an_on});
      @(posedge clk);
      arst_n <= 1'b1;
      bus_rd(12'h11C, 32'h0000C863);
      $display("second reset done");
      end_of_test();
   end
endmodule // test_usb_phy_ctrl_regs
`default_nettype wire
